// ### hdl/pcm_pkg.sv
// Constants for the command-coded register map of the power manager.
// Assumes a serial-link front end that presents decoded command transactions.
// Functional notes
// [R1] Byte read of 0x7E returns non-paged communication and memory status.
// [R2] Code 0x80 returns vendor fault/state byte of the selected page.
// [R3] Codes 0x88 and 0x8D return input voltage and die temperature words.
// [R4] Code 0x8B returns selected channel output voltage word.
// [R5] Byte read of 0x98 always returns 0x11.
// [R6] Code 0xB7 returns paged extra vendor status word.
// [R7] Host unlocks at 0xBD first; memory access only after valid unlock.
// [R8] Write to 0xBE erases user memory for bulk programming.
// [R9] Each word transfer at 0xBF advances the memory pointer by one.
// [R10] Word 0xC0 holds a command selection shared by all alternate hosts.
// [R11] Codes 0xC1 and 0xC2 carry selected data for alternate hosts.
// [R12] Code 0xCF returns all channel telemetry as one block.
// [R13] Paged channel configuration at 0xD0, reset 0x0080 per channel.
// [R14] Global configuration at 0xD1, reset 0x1C7B.
// [R15] Paged byte 0xD2 gates faulted-off onto fault lines 00 and 10.
// [R16] Paged byte 0xD3 gates faulted-off onto fault lines 01 and 11.
// [R17] Power-good pin follows channels and watchdog as mapped by 0xD4.
// [R18] Writes to read-only codes ignored; bad accesses flagged in status.
// [R19] Erase and data accesses refused until unlocked; contents unchanged.
package pcm_pkg;
   localparam int NUM_CH = 8;
   localparam logic [7:0] CMD_COMM_STATUS = 8'h7E;
   localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
   localparam logic [7:0] CMD_VIN = 8'h88;
   localparam logic [7:0] CMD_VOUT = 8'h8B;
   localparam logic [7:0] CMD_TEMP = 8'h8D;
   localparam logic [7:0] CMD_REVISION = 8'h98;
   localparam logic [7:0] CMD_TOOL_A = 8'hB0;
   localparam logic [7:0] CMD_TOOL_B = 8'hB1;
   localparam logic [7:0] CMD_OEM = 8'hB2;
   localparam logic [7:0] CMD_PAGED_SCRATCH = 8'hB3;
   localparam logic [7:0] CMD_GLOBAL_SCRATCH = 8'hB4;
   localparam logic [7:0] CMD_VENDOR_RSV_A = 8'hB5;
   localparam logic [7:0] CMD_INFO = 8'hB6;
   localparam logic [7:0] CMD_EXTRA_STATUS = 8'hB7;
   localparam logic [7:0] CMD_VENDOR_RSV_B = 8'hBC;
   localparam logic [7:0] CMD_NVM_UNLOCK = 8'hBD;
   localparam logic [7:0] CMD_NVM_ERASE = 8'hBE;
   localparam logic [7:0] CMD_NVM_DATA = 8'hBF;
   localparam logic [7:0] CMD_ALT_COMMAND = 8'hC0;
   localparam logic [7:0] CMD_ALT0_DATA = 8'hC1;
   localparam logic [7:0] CMD_ALT1_DATA = 8'hC2;
   localparam logic [7:0] CMD_TELEMETRY = 8'hCF;
   localparam logic [7:0] CMD_CH_CONFIG = 8'hD0;
   localparam logic [7:0] CMD_GLB_CONFIG = 8'hD1;
   localparam logic [7:0] CMD_PROP_A = 8'hD2;
   localparam logic [7:0] CMD_PROP_B = 8'hD3;
   localparam logic [7:0] CMD_PG_MAP = 8'hD4;
   localparam logic [7:0] REVISION_VALUE = 8'h11;
   localparam logic [15:0] CH_CONFIG_RST = 16'h0080;
   localparam logic [15:0] GLB_CONFIG_RST = 16'h1C7B;
   localparam logic [7:0] PROP_RST = 8'h00;
   localparam logic [15:0] PG_MAP_RST = 16'h0000;
   localparam logic [15:0] SCRATCH_RST = 16'h0000;
   localparam logic [15:0] NVM_ERASED = 16'hFFFF;
   localparam logic [7:0] NVM_UNLOCK_CODE = 8'h2B;
   localparam logic [7:0] NVM_ERASE_CODE = 8'hC4;
   localparam logic [7:0] TELEMETRY_COUNT = 8'h10;
   // Status bit positions
   localparam int CML_INVALID_CMD = 7;
   localparam int CML_READ_ONLY = 6;
   localparam int CML_MEM_FAULT = 4;
   // Power-good map and fault-line select fields
   localparam int PG_MAP_WD_BIT = 15;
   localparam int PROP_LINE_LO = 0;
   localparam int PROP_LINE_HI = 1;
endpackage

// ### hdl/pcm_command_map.sv
// Command-coded register map: status, telemetry, user words, user memory,
// alternate-host ports, configuration, fault line and power-good drive.
// Assumes the link front end delivers one decoded transaction per request pulse
// and that telemetry and status inputs come from logic on clock_in.
module pcm_command_map #(
   parameter int NVM_DEPTH = 16,
   parameter int NVM_AW = 4
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [7:0] req_code_in,
   input wire logic [15:0] req_wdata_in,
   input wire logic [2:0] req_page_in,
   input wire logic [4:0] req_index_in,
   input wire logic clear_faults_in,
   input wire logic [15:0] vin_reading_in,
   input wire logic [15:0] temp_reading_in,
   input wire logic [pcm_pkg::NUM_CH-1:0][15:0] vout_reading_in,
   input wire logic [pcm_pkg::NUM_CH-1:0][7:0] vendor_status_in,
   input wire logic [pcm_pkg::NUM_CH-1:0][15:0] extra_status_in,
   input wire logic [15:0] vendor_info_in,
   input wire logic [pcm_pkg::NUM_CH-1:0] channel_faulted_in,
   input wire logic [pcm_pkg::NUM_CH-1:0] channel_pg_in,
   input wire logic watchdog_ok_in,
   output logic rsp_valid_out,
   output logic rsp_error_out,
   output logic [15:0] rsp_data_out,
   output logic [3:0] fault_share_line_out,
   output logic [3:0] fault_share_line_oe_out,
   output logic power_good_output_out,
   output logic [15:0] channel_config_out,
   output logic [15:0] global_config_out
);
   import pcm_pkg::*;

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      logic rsp_valid;
      logic rsp_err;
      logic [15:0] rsp_data;
      logic [7:0] cml;
      logic unlocked;
      logic [NVM_AW-1:0] ptr;
      logic [NVM_DEPTH-1:0][15:0] mem;
      logic [15:0] tool_a;
      logic [15:0] oem;
      logic [15:0] glb_scratch;
      logic [NUM_CH-1:0][15:0] tool_b;
      logic [NUM_CH-1:0][15:0] pg_scratch;
      logic [NUM_CH-1:0][15:0] rsv_a;
      logic [NUM_CH-1:0][15:0] rsv_b;
      logic [15:0] alt_cmd;
      logic [NUM_CH-1:0][15:0] ch_cfg;
      logic [15:0] glb_cfg;
      logic [NUM_CH-1:0][7:0] prop_a;
      logic [NUM_CH-1:0][7:0] prop_b;
      logic [15:0] pg_map;
      logic [3:0] flt;
      logic pg;
   } pcm_state_t;

   localparam pcm_state_t STATE_RST = '{
      rsp_valid: 1'b0, rsp_err: 1'b0, rsp_data: 16'h0000, cml: 8'h00,
      unlocked: 1'b0, ptr: '0, mem: {NVM_DEPTH{NVM_ERASED}},
      tool_a: SCRATCH_RST, oem: SCRATCH_RST, glb_scratch: SCRATCH_RST,
      tool_b: {NUM_CH{SCRATCH_RST}}, pg_scratch: {NUM_CH{SCRATCH_RST}},
      rsv_a: {NUM_CH{SCRATCH_RST}}, rsv_b: {NUM_CH{SCRATCH_RST}},
      alt_cmd: 16'h0000, ch_cfg: {NUM_CH{CH_CONFIG_RST}}, glb_cfg: GLB_CONFIG_RST,
      prop_a: {NUM_CH{PROP_RST}}, prop_b: {NUM_CH{PROP_RST}},
      pg_map: PG_MAP_RST, flt: 4'h0, pg: 1'b1};

   pcm_state_t st_ff;
   pcm_state_t nxt_st;

   // ---------------------------------------------
   // Read decode, shared by direct and alternate access
   // ---------------------------------------------
   // Returns {ok, read_only, data}
   function automatic logic [17:0] read_value(input logic [7:0] code, input logic [2:0] pg,
                                              input logic [4:0] idx, input pcm_state_t s);
      logic [17:0] r;
      logic [3:0] ch;
      r = 18'h0;
      ch = 4'(idx - 5'd1) >> 1;
      unique case (code)
         CMD_COMM_STATUS: r = {2'b11, 8'h00, s.cml}; // R1
         CMD_VENDOR_STATUS: r = {2'b11, 8'h00, vendor_status_in[pg]}; // R2
         CMD_VIN: r = {2'b11, vin_reading_in}; // R3
         CMD_VOUT: r = {2'b11, vout_reading_in[pg]}; // R4
         CMD_TEMP: r = {2'b11, temp_reading_in}; // R3
         CMD_REVISION: r = {2'b11, 8'h00, REVISION_VALUE}; // R5
         CMD_INFO: r = {2'b11, vendor_info_in};
         CMD_EXTRA_STATUS: r = {2'b11, extra_status_in[pg]}; // R6
         CMD_TELEMETRY: begin // R12
            if (idx == 5'd0) begin
               r = {2'b11, 8'h00, TELEMETRY_COUNT};
            end else if (idx <= 5'(TELEMETRY_COUNT)) begin
               r = {2'b11, 8'h00, idx[0] ? vout_reading_in[ch[2:0]][7:0] : vout_reading_in[ch[2:0]][15:8]};
            end else begin
               r = 18'h0;
            end
         end
         CMD_TOOL_A: r = {2'b10, s.tool_a};
         CMD_TOOL_B: r = {2'b10, s.tool_b[pg]};
         CMD_OEM: r = {2'b10, s.oem};
         CMD_PAGED_SCRATCH: r = {2'b10, s.pg_scratch[pg]};
         CMD_GLOBAL_SCRATCH: r = {2'b10, s.glb_scratch};
         CMD_VENDOR_RSV_A: r = {2'b10, s.rsv_a[pg]};
         CMD_VENDOR_RSV_B: r = {2'b10, s.rsv_b[pg]};
         CMD_NVM_UNLOCK: r = {2'b10, 15'h0, s.unlocked};
         CMD_NVM_ERASE: r = {2'b10, 16'h0000};
         CMD_ALT_COMMAND: r = {2'b10, s.alt_cmd}; // R10
         CMD_CH_CONFIG: r = {2'b10, s.ch_cfg[pg]}; // R13
         CMD_GLB_CONFIG: r = {2'b10, s.glb_cfg}; // R14
         CMD_PROP_A: r = {2'b10, 8'h00, s.prop_a[pg]}; // R15
         CMD_PROP_B: r = {2'b10, 8'h00, s.prop_b[pg]}; // R16
         CMD_PG_MAP: r = {2'b10, s.pg_map}; // R17
         default: r = 18'h0;
      endcase
      return r;
   endfunction

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      logic [7:0] eff;
      logic alt;
      logic [17:0] rv;
      logic pg_all;
      nxt_st = st_ff;
      eff = req_code_in;
      alt = 1'b0;
      rv = 18'h0;
      pg_all = 1'b1;
      nxt_st.rsp_valid = 1'b0;
      nxt_st.rsp_err = 1'b0;
      // Clear first so a same-cycle event still sets its bit
      if (clear_faults_in) begin
         nxt_st.cml = 8'h00;
      end
      if (req_valid_in) begin
         alt = (req_code_in == CMD_ALT0_DATA) || (req_code_in == CMD_ALT1_DATA);
         if (alt) begin
            eff = st_ff.alt_cmd[7:0]; // R11
         end
         nxt_st.rsp_valid = 1'b1;
         nxt_st.rsp_data = 16'h0000;
         // A port pointing at a port would recurse; treat as invalid
         if (alt && (eff == CMD_ALT0_DATA || eff == CMD_ALT1_DATA)) begin
            nxt_st.rsp_err = 1'b1;
            nxt_st.cml[CML_INVALID_CMD] = 1'b1; // R18
         end else if (eff == CMD_NVM_DATA) begin
            if (!st_ff.unlocked) begin
               nxt_st.rsp_err = 1'b1; // R19
               nxt_st.cml[CML_MEM_FAULT] = 1'b1; // R19
            end else begin
               if (req_write_in) begin
                  nxt_st.mem[st_ff.ptr] = req_wdata_in; // R9
               end else begin
                  nxt_st.rsp_data = st_ff.mem[st_ff.ptr];
               end
               nxt_st.ptr = st_ff.ptr + 1'b1; // R9
            end
         end else if (req_write_in) begin
            rv = read_value(eff, req_page_in, req_index_in, st_ff);
            if (rv[16]) begin
               nxt_st.rsp_err = 1'b1; // R18
               nxt_st.cml[CML_READ_ONLY] = 1'b1; // R18
            end else begin
               unique case (eff)
                  CMD_TOOL_A: nxt_st.tool_a = req_wdata_in;
                  CMD_TOOL_B: nxt_st.tool_b[req_page_in] = req_wdata_in;
                  CMD_OEM: nxt_st.oem = req_wdata_in;
                  CMD_PAGED_SCRATCH: nxt_st.pg_scratch[req_page_in] = req_wdata_in;
                  CMD_GLOBAL_SCRATCH: nxt_st.glb_scratch = req_wdata_in;
                  CMD_VENDOR_RSV_A: nxt_st.rsv_a[req_page_in] = req_wdata_in;
                  CMD_VENDOR_RSV_B: nxt_st.rsv_b[req_page_in] = req_wdata_in;
                  CMD_NVM_UNLOCK: begin
                     // Any other value locks again
                     nxt_st.unlocked = (req_wdata_in[7:0] == NVM_UNLOCK_CODE); // R7
                     nxt_st.ptr = '0;
                  end
                  CMD_NVM_ERASE: begin
                     if (st_ff.unlocked && req_wdata_in[7:0] == NVM_ERASE_CODE) begin
                        nxt_st.mem = {NVM_DEPTH{NVM_ERASED}}; // R8
                        nxt_st.ptr = '0;
                     end else begin
                        nxt_st.rsp_err = 1'b1; // R19
                        nxt_st.cml[CML_MEM_FAULT] = 1'b1; // R19
                     end
                  end
                  CMD_ALT_COMMAND: nxt_st.alt_cmd = req_wdata_in; // R10
                  CMD_CH_CONFIG: nxt_st.ch_cfg[req_page_in] = req_wdata_in; // R13
                  CMD_GLB_CONFIG: nxt_st.glb_cfg = req_wdata_in; // R14
                  CMD_PROP_A: nxt_st.prop_a[req_page_in] = req_wdata_in[7:0]; // R15
                  CMD_PROP_B: nxt_st.prop_b[req_page_in] = req_wdata_in[7:0]; // R16
                  CMD_PG_MAP: nxt_st.pg_map = req_wdata_in; // R17
                  default: begin
                     nxt_st.rsp_err = 1'b1;
                     nxt_st.cml[CML_INVALID_CMD] = 1'b1; // R18
                  end
               endcase
            end
         end else begin
            rv = read_value(eff, req_page_in, req_index_in, st_ff);
            nxt_st.rsp_data = rv[15:0];
            if (!rv[17]) begin
               nxt_st.rsp_err = 1'b1;
               nxt_st.cml[CML_INVALID_CMD] = 1'b1; // R18
            end
         end
      end
      // Fault lines: 0=line 00, 1=line 01, 2=line 10, 3=line 11
      nxt_st.flt = 4'h0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (channel_faulted_in[i]) begin
            nxt_st.flt[0] = nxt_st.flt[0] | st_ff.prop_a[i][PROP_LINE_LO]; // R15
            nxt_st.flt[2] = nxt_st.flt[2] | st_ff.prop_a[i][PROP_LINE_HI]; // R15
            nxt_st.flt[1] = nxt_st.flt[1] | st_ff.prop_b[i][PROP_LINE_LO]; // R16
            nxt_st.flt[3] = nxt_st.flt[3] | st_ff.prop_b[i][PROP_LINE_HI]; // R16
         end
         if (st_ff.pg_map[i] && !channel_pg_in[i]) begin
            pg_all = 1'b0; // R17
         end
      end
      if (st_ff.pg_map[PG_MAP_WD_BIT] && !watchdog_ok_in) begin
         pg_all = 1'b0; // R17
      end
      nxt_st.pg = pg_all;
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_ff <= STATE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rsp_valid_out = st_ff.rsp_valid;
   assign rsp_error_out = st_ff.rsp_err;
   assign rsp_data_out = st_ff.rsp_data;
   // Open drain: only ever pulls low
   assign fault_share_line_out = 4'h0;
   assign fault_share_line_oe_out = st_ff.flt;
   assign power_good_output_out = st_ff.pg;
   assign channel_config_out = st_ff.ch_cfg[req_page_in];
   assign global_config_out = st_ff.glb_cfg;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   sequence s_rd(logic [7:0] c);
      req_valid_in && !req_write_in && req_code_in == c;
   endsequence
   sequence s_wr(logic [7:0] c);
      req_valid_in && req_write_in && req_code_in == c;
   endsequence

   property p_revision;
      s_rd(CMD_REVISION) |=> rsp_valid_out && rsp_data_out == 16'h0011 && !rsp_error_out;
   endproperty
   a_revision: assert property (p_revision) else $error("revision read wrong"); // R5

   property p_ro_write;
      s_wr(CMD_VIN) |=> rsp_error_out && st_ff.cml[CML_READ_ONLY];
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write not flagged"); // R18

   property p_locked_data;
      (s_wr(CMD_NVM_DATA) and !st_ff.unlocked) |=> rsp_error_out && $stable(st_ff.mem) && $stable(st_ff.ptr);
   endproperty
   a_locked_data: assert property (p_locked_data) else $error("locked data access altered memory"); // R19

   property p_unlock_erase;
      (s_wr(CMD_NVM_UNLOCK) and req_wdata_in[7:0] == NVM_UNLOCK_CODE) ##1
         (s_wr(CMD_NVM_ERASE) and req_wdata_in[7:0] == NVM_ERASE_CODE)
         |=> st_ff.ptr == '0 && st_ff.mem[0] == NVM_ERASED && !rsp_error_out;
   endproperty
   a_unlock_erase: assert property (p_unlock_erase) else $error("erase after unlock failed"); // R8

   property p_data_advance;
      (s_wr(CMD_NVM_DATA) and st_ff.unlocked) |=> st_ff.ptr == $past(st_ff.ptr) + 1'b1;
   endproperty
   a_data_advance: assert property (p_data_advance) else $error("pointer did not advance"); // R9

   property p_alt_port;
      (s_wr(CMD_ALT_COMMAND) and req_wdata_in[7:0] == CMD_REVISION) ##1 s_rd(CMD_ALT1_DATA)
         |=> rsp_data_out == 16'h0011;
   endproperty
   a_alt_port: assert property (p_alt_port) else $error("alternate port did not follow command"); // R11

   property p_telemetry_count;
      (s_rd(CMD_TELEMETRY) and req_index_in == 5'd0) |=> rsp_data_out == 16'h0010;
   endproperty
   a_telemetry_count: assert property (p_telemetry_count) else $error("block count wrong"); // R12

   property p_fault_line;
      channel_faulted_in[0] && st_ff.prop_a[0][PROP_LINE_LO] |=> fault_share_line_oe_out[0];
   endproperty
   a_fault_line: assert property (p_fault_line) else $error("fault line not pulled"); // R15

   property p_pg_free;
      st_ff.pg_map == 16'h0000 |=> power_good_output_out;
   endproperty
   a_pg_free: assert property (p_pg_free) else $error("power good low with empty map"); // R17

   property p_locked_erase;
      (s_wr(CMD_NVM_ERASE) and !st_ff.unlocked) |=>
         rsp_error_out && st_ff.cml[CML_MEM_FAULT] && $stable(st_ff.mem);
   endproperty
   a_locked_erase: assert property (p_locked_erase) else $error("locked erase not refused"); // R19

   property p_status_read;
      s_rd(CMD_COMM_STATUS) |=> rsp_data_out == {8'h00, $past(st_ff.cml)} && !rsp_error_out;
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong"); // R1

   property p_vin_read;
      s_rd(CMD_VIN) |=> rsp_data_out == $past(vin_reading_in) && !rsp_error_out;
   endproperty
   a_vin_read: assert property (p_vin_read) else $error("input voltage read wrong"); // R3

   property p_vout_read;
      s_rd(CMD_VOUT) |=> rsp_data_out == $past(vout_reading_in[req_page_in]) && !rsp_error_out;
   endproperty
   a_vout_read: assert property (p_vout_read) else $error("output voltage read wrong"); // R4

   property p_ch_cfg_write;
      s_wr(CMD_CH_CONFIG) |=> st_ff.ch_cfg[$past(req_page_in)] == $past(req_wdata_in) && !rsp_error_out;
   endproperty
   a_ch_cfg_write: assert property (p_ch_cfg_write) else $error("channel config write lost"); // R13

   property p_pg_watchdog;
      st_ff.pg_map[PG_MAP_WD_BIT] && !watchdog_ok_in |=> !power_good_output_out;
   endproperty
   a_pg_watchdog: assert property (p_pg_watchdog) else $error("power good ignores watchdog"); // R17

   property p_fault_line_b;
      channel_faulted_in[2] && st_ff.prop_b[2][PROP_LINE_LO] |=> fault_share_line_oe_out[1];
   endproperty
   a_fault_line_b: assert property (p_fault_line_b) else $error("second fault line not pulled"); // R16
endmodule

// ### verif/pcm_host_model.sv
// Host-side driver of decoded command transactions for the register map.
// Assumes one request per rising edge of clock_in; callers chain them freely.
module pcm_host_model (
   input wire logic clock_in,
   output logic req_valid_out,
   output logic req_write_out,
   output logic [7:0] req_code_out,
   output logic [15:0] req_wdata_out,
   output logic [2:0] req_page_out,
   output logic [4:0] req_index_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      req_valid_out = 1'b0;
      req_write_out = 1'b0;
      req_code_out = 8'h00;
      req_wdata_out = 16'h0000;
      req_page_out = 3'h0;
      req_index_out = 5'h00;
   end
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [2:0] p,
                       input logic [4:0] i);
      @(posedge clock_in);
      req_valid_out <= 1'b1;
      req_write_out <= w;
      req_code_out <= c;
      req_wdata_out <= d;
      req_page_out <= p;
      req_index_out <= i;
   endtask
   // Released write, code and data flip so a stale value never passes for a request
   task automatic idle();
      @(posedge clock_in);
      req_valid_out <= 1'b0;
      req_write_out <= ~req_write_out;
      req_code_out <= ~req_code_out;
      req_wdata_out <= ~req_wdata_out;
   endtask
endmodule

// ### verif/power_manager_command_map_c_tb.sv
// Self-checking bench for the command-coded register map.
// Assumes the host model drives requests; responses are checked from a queue.
module power_manager_command_map_c_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcm_pkg::*;
   logic clock_in, rstn_in, clr_f, rv, rw, wdok, rsp_v, rsp_e, pg_o;
   logic [7:0] rc;
   logic [15:0] rd_w, vin, temp, info, rsp_d, ccfg, gcfg, g;
   logic [2:0] rp;
   logic [4:0] ri;
   logic [NUM_CH-1:0][15:0] vout, xst;
   logic [NUM_CH-1:0][7:0] vst;
   logic [NUM_CH-1:0] flt, pgi;
   logic [3:0] fl, fl_oe;
   logic [17:0] expq[$];
   logic [15:0] d[3];
   int err_total, n_checks, seed;
   pcm_host_model pcm_host_model_inst (.clock_in(clock_in), .req_valid_out(rv), .req_write_out(rw),
      .req_code_out(rc), .req_wdata_out(rd_w), .req_page_out(rp), .req_index_out(ri));
   pcm_command_map pcm_command_map_inst (.clock_in(clock_in), .rstn_in(rstn_in), .req_valid_in(rv),
      .req_write_in(rw), .req_code_in(rc), .req_wdata_in(rd_w), .req_page_in(rp), .req_index_in(ri),
      .clear_faults_in(clr_f), .vin_reading_in(vin), .temp_reading_in(temp), .vout_reading_in(vout),
      .vendor_status_in(vst), .extra_status_in(xst), .vendor_info_in(info), .channel_faulted_in(flt),
      .channel_pg_in(pgi), .watchdog_ok_in(wdok), .rsp_valid_out(rsp_v), .rsp_error_out(rsp_e),
      .rsp_data_out(rsp_d), .fault_share_line_out(fl), .fault_share_line_oe_out(fl_oe),
      .power_good_output_out(pg_o), .channel_config_out(ccfg), .global_config_out(gcfg));
   // ----------------------------------------
   // Checking and reporting
   // ----------------------------------------
   task automatic fail(input string m);
      err_total++;
      $display("MISMATCH t=%0t %s", $time, m);
   endtask
   task automatic chk_rsp(input logic [17:0] x);
      n_checks++;
      if (rsp_e !== x[16] || (x[17] === 1'b1 && rsp_d !== x[15:0])) begin
         fail($sformatf("response err=%b data=%h expected %h", rsp_e, rsp_d, x));
      end
   endtask
   task automatic chk_pin(input logic [15:0] got, input logic [15:0] x);
      n_checks++;
      if (got !== x) begin
         fail($sformatf("pin value %h expected %h", got, x));
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Error reads leave data unchecked: only the flag is defined then
   task automatic rd(input logic [7:0] c, input logic [2:0] p, input logic [4:0] i, input logic e,
                     input logic [15:0] v);
      expq.push_back({~e, e, v});
      pcm_host_model_inst.xfer(1'b0, c, 16'h0000, p, i);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] v, input logic [2:0] p, input logic e);
      expq.push_back({~e, e, 16'h0000});
      pcm_host_model_inst.xfer(1'b1, c, v, p, 5'h00);
   endtask
   task automatic clr();
      pcm_host_model_inst.idle();
      clr_f <= 1'b1;
      @(posedge clock_in);
      clr_f <= 1'b0;
   endtask
   task automatic pins(input logic [7:0] f, input logic [7:0] p, input logic w);
      pcm_host_model_inst.idle();
      flt <= f;
      pgi <= p;
      wdok <= w;
      repeat (2) @(posedge clock_in);
      #1;
   endtask
   always @(posedge clock_in) begin
      if (rsp_v === 1'b1) begin
         if (expq.size() == 0) fail("response without request");
         else chk_rsp(expq.pop_front());
      end
   end
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   initial begin
      #100000;
      fail("timeout");
      results();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 86272;
      err_total = 0;
      n_checks = 0;
      {rstn_in, clr_f, wdok, flt, pgi, vin, temp, info, vout, xst, vst} = '0;
      repeat (6) @(posedge clock_in);
      rstn_in <= 1'b1;
      vin <= 16'($random(seed));
      temp <= 16'($random(seed));
      info <= 16'($random(seed));
      pgi <= 8'($random(seed));
      for (int k = 0; k < NUM_CH; k++) begin
         vout[k] <= 16'($random(seed));
         xst[k] <= 16'($random(seed));
         vst[k] <= 8'($random(seed));
      end
      #1;
      chk_pin(gcfg, GLB_CONFIG_RST);
      chk_pin(ccfg, CH_CONFIG_RST);
      chk_pin({15'h0000, pg_o}, 16'h0001);
      rd(CMD_REVISION, 0, 0, 0, {8'h00, REVISION_VALUE});
      rd(CMD_CH_CONFIG, 7, 0, 0, CH_CONFIG_RST);
      rd(CMD_GLB_CONFIG, 0, 0, 0, GLB_CONFIG_RST);
      rd(CMD_PROP_A, 5, 0, 0, {8'h00, PROP_RST});
      rd(CMD_PROP_B, 6, 0, 0, {8'h00, PROP_RST});
      rd(CMD_PG_MAP, 0, 0, 0, PG_MAP_RST);
      rd(CMD_PAGED_SCRATCH, 4, 0, 0, SCRATCH_RST);
      rd(CMD_VIN, 0, 0, 0, vin);
      rd(CMD_TEMP, 0, 0, 0, temp);
      rd(CMD_INFO, 0, 0, 0, info);
      rd(CMD_TELEMETRY, 0, 0, 0, {8'h00, TELEMETRY_COUNT});
      for (int k = 0; k < NUM_CH; k++) begin
         rd(CMD_VOUT, 3'(k), 0, 0, vout[k]);
         rd(CMD_VENDOR_STATUS, 3'(k), 0, 0, {8'h00, vst[k]});
         rd(CMD_EXTRA_STATUS, 3'(k), 0, 0, xst[k]);
         rd(CMD_TELEMETRY, 0, 5'(2 * k + 1), 0, {8'h00, vout[k][7:0]});
         rd(CMD_TELEMETRY, 0, 5'(2 * k + 2), 0, {8'h00, vout[k][15:8]});
      end
      wr(CMD_REVISION, 16'h0055, 0, 1);
      wr(CMD_VIN, 16'h1234, 0, 1);
      rd(CMD_REVISION, 0, 0, 0, {8'h00, REVISION_VALUE});
      wr(8'h81, 16'h0000, 0, 1);
      pcm_host_model_inst.idle();
      rd(CMD_COMM_STATUS, 0, 0, 0, 16'h00C0);
      clr();
      rd(CMD_COMM_STATUS, 0, 0, 0, 16'h0000);
      rd(CMD_NVM_DATA, 0, 0, 1, 16'h0000);
      wr(CMD_NVM_ERASE, {8'h00, NVM_ERASE_CODE}, 0, 1);
      pcm_host_model_inst.idle();
      rd(CMD_COMM_STATUS, 0, 0, 0, 16'h0010);
      clr();
      wr(CMD_NVM_UNLOCK, {8'h00, NVM_UNLOCK_CODE}, 0, 0);
      wr(CMD_NVM_ERASE, {8'h00, NVM_ERASE_CODE}, 0, 0);
      for (int i = 0; i < 3; i++) begin
         d[i] = 16'($random(seed));
         wr(CMD_NVM_DATA, d[i], 0, 0);
      end
      wr(CMD_NVM_UNLOCK, {8'h00, NVM_UNLOCK_CODE}, 0, 0);
      for (int i = 0; i < 3; i++) rd(CMD_NVM_DATA, 0, 0, 0, d[i]);
      rd(CMD_NVM_DATA, 0, 0, 0, NVM_ERASED);
      wr(CMD_NVM_UNLOCK, 16'h0000, 0, 0);
      wr(CMD_NVM_DATA, ~d[0], 0, 1);
      wr(CMD_NVM_UNLOCK, {8'h00, NVM_UNLOCK_CODE}, 0, 0);
      rd(CMD_NVM_DATA, 0, 0, 0, d[0]);
      g = 16'($random(seed));
      wr(CMD_ALT_COMMAND, {8'h00, CMD_GLB_CONFIG}, 0, 0);
      rd(CMD_ALT0_DATA, 0, 0, 0, GLB_CONFIG_RST);
      wr(CMD_ALT1_DATA, g, 0, 0);
      rd(CMD_GLB_CONFIG, 0, 0, 0, g);
      rd(CMD_ALT_COMMAND, 0, 0, 0, {8'h00, CMD_GLB_CONFIG});
      wr(CMD_ALT_COMMAND, {8'h00, CMD_REVISION}, 0, 0);
      rd(CMD_ALT1_DATA, 0, 0, 0, {8'h00, REVISION_VALUE});
      wr(CMD_ALT_COMMAND, {8'h00, CMD_ALT0_DATA}, 0, 0);
      rd(CMD_ALT1_DATA, 0, 0, 1, 16'h0000);
      clr();
      wr(CMD_CH_CONFIG, ~g, 3, 0);
      rd(CMD_CH_CONFIG, 2, 0, 0, CH_CONFIG_RST);
      rd(CMD_CH_CONFIG, 3, 0, 0, ~g);
      wr(CMD_PROP_A, 16'h0002, 2, 0);
      wr(CMD_PROP_B, 16'h0001, 2, 0);
      wr(CMD_PROP_A, 16'h0001, 0, 0);
      wr(CMD_PG_MAP, 16'h8003, 3, 0);
      pins(8'h20, 8'h03, 1'b1);
      chk_pin(gcfg, g);
      chk_pin(ccfg, ~g);
      chk_pin({12'h000, fl_oe}, 16'h0000);
      chk_pin({15'h0000, pg_o}, 16'h0001);
      pins(8'h04, 8'h03, 1'b0);
      chk_pin({12'h000, fl_oe}, 16'h0006);
      chk_pin({12'h000, fl}, 16'h0000);
      chk_pin({15'h0000, pg_o}, 16'h0000);
      pins(8'h01, 8'h03, 1'b1);
      chk_pin({12'h000, fl_oe}, 16'h0001);
      chk_pin({15'h0000, pg_o}, 16'h0001);
      pins(8'h00, 8'h02, 1'b1);
      chk_pin({15'h0000, pg_o}, 16'h0000);
      repeat (4) @(posedge clock_in);
      if (expq.size() != 0) fail("responses missing");
      results();
   end
endmodule
